// >>> dram_refresh_ap_timing.v
// Functional notes
// - Seamless reads/writes to other banks accepted.
// - Mode one bit 7 selects read postamble.
// - Mode one bit 2 selects write preamble.
// - Read auto precharge uses mode two cycles.
// - Write auto precharge uses mode one recovery.
// - Internal precharge deferred until row time met.
// - Refresh decoded from select and address bits.
// - Address bit five selects per-bank or all-bank.
// - Per-bank target taken on second edge.
// - Per-bank refreshes accepted in any order.
// - Bank count zeroed on reset, exit, all-bank.
// - All-bank uses current row, then row advances.
// - All-bank or self refresh allowed any time.
// - Refreshed bank busy, others usable, then idle.
//
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
`include "dram_ref_consts.vh"

module dram_refresh_ap_timing (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        ck,
  input  wire        cs,
  input  wire [5:0]  ca,
  output wire [7:0]  bank_active,
  output wire [7:0]  bank_refreshing,
  output reg  [15:0] refresh_row_r,
  output reg         refresh_pulse_r
);
  // Decoder states, one-hot.
  localparam [1:0] ST_FIRST  = 2'b01;
  localparam [1:0] ST_SECOND = 2'b10;

  reg  [2:0]  ck_sync_r;      // Link clock: two sync stages plus a history stage.
  reg  [1:0]  cs_sync_r;      // Chip select synchroniser.
  reg  [5:0]  ca_meta_r;      // First stage of the command/address synchroniser.
  reg  [5:0]  ca_sync_r;      // Second stage, the only one logic reads.
  wire        tick;           // One hclk pulse per rising link clock edge.
  reg  [1:0]  state_r;        // Decoder state.
  reg  [4:0]  cmd_r;          // Command code held from the first edge.
  reg         all_bank_r;     // Refresh type held from the first edge.
  reg  [31:0] mode1_r;        // Mode register one.
  reg  [31:0] mode2_r;        // Mode register two.
  reg  [31:0] ctrl_r;         // Control register.
  reg  [2:0]  bank_cnt_r;     // Per-bank refresh count within the set.
  reg  [15:0] row_cnt_r;      // Row counter used by the next refresh.
  reg         srx_r;          // Self refresh exit request, one cycle.
  reg         dph_r;          // An AHB data phase is in progress.
  reg         dph_wr_r;       // That data phase is a write.
  reg  [7:0]  dph_addr_r;     // Register offset of that data phase.
  reg  [31:0] hrdata_r;       // Read data, loaded in the address phase.
  reg  [7:0]  gap_r;          // Read-AP to write gap for the current setup.
  reg  [7:0]  ev_act;         // Per-bank decoded events for this tick.
  reg  [7:0]  ev_pre;
  reg  [7:0]  ev_rd;
  reg  [7:0]  ev_wr;
  reg  [7:0]  ev_ref;
  reg  [7:0]  half_bl;        // Half the burst length in link cycles.
  reg  [7:0]  rpst;           // Read postamble, whole cycles rounded down.
  reg  [7:0]  wpre;           // Write preamble in cycles.
  reg  [8:0]  gap_base;       // Read side of the gap.
  reg  [8:0]  gap_sub;        // Write side subtracted from it.
  reg  [7:0]  gap_nxt;        // Clamped gap.
  reg  [8:0]  gap_diff;       // Unclamped gap, one bit wider than the result.
  reg  [7:0]  rd_ap_dly;      // Burst-to-internal-precharge delay after read AP.
  reg  [7:0]  wr_ap_dly;      // Same after write AP.
  reg  [31:0] rd_mux;         // Read multiplexer.
  wire        addr_ok;        // Valid address phase for this slave.
  wire        second_edge;    // A second command edge is being taken now.
  wire [7:0]  sel_bank;       // One-hot bank on the second edge.

  // Synchronise the link pins; nothing reads the first stages.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ck_sync_r <= 3'b000;
      cs_sync_r <= 2'b00;
      ca_meta_r <= 6'h00;
      ca_sync_r <= 6'h00;
    end else begin
      ck_sync_r <= {ck_sync_r[1:0], ck};
      cs_sync_r <= {cs_sync_r[0], cs};
      ca_meta_r <= ca;
      ca_sync_r <= ca_meta_r;
    end
  end

  // Rising link edge, seen on the synchronised copy.
  assign tick        = ck_sync_r[1] & ~ck_sync_r[2];
  assign second_edge = tick & (state_r == ST_SECOND);
  assign sel_bank    = 8'h01 << ca_sync_r[2:0];

  // Two-edge command decoder: first edge carries the code, second the bank.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r    <= ST_FIRST;
      cmd_r      <= 5'h00;
      all_bank_r <= 1'b0;
    end else if (tick) begin
      case (state_r)
        ST_FIRST: begin
          // Chip select high with a known code opens a command.
          if (cs_sync_r[1] && (ca_sync_r[4:0] == `CA_REF || ca_sync_r[4:0] == `CA_ACT ||
              ca_sync_r[4:0] == `CA_RDAP || ca_sync_r[4:0] == `CA_WRAP ||
              ca_sync_r[4:0] == `CA_PRE)) begin
            cmd_r      <= ca_sync_r[4:0];
            all_bank_r <= ca_sync_r[5];
            state_r    <= ST_SECOND;
          end
        end
        ST_SECOND: begin
          state_r <= ST_FIRST;
        end
        default: begin
          state_r <= ST_FIRST;
        end
      endcase
    end
  end

  // Turn the second edge into per-bank events.
  always @* begin
    ev_act = 8'h00;
    ev_pre = 8'h00;
    ev_rd  = 8'h00;
    ev_wr  = 8'h00;
    ev_ref = 8'h00;
    if (state_r == ST_SECOND) begin
      case (cmd_r)
        `CA_ACT:  ev_act = sel_bank;
        // Precharge with bit five set closes every bank.
        `CA_PRE:  ev_pre = all_bank_r ? 8'hFF : sel_bank;
        // Auto precharge to one bank leaves the others seamless.
        `CA_RDAP: ev_rd  = sel_bank;
        `CA_WRAP: ev_wr  = sel_bank;
        // Per-bank target from address bits 2..0; all-bank hits all.
        `CA_REF:  ev_ref = all_bank_r ? 8'hFF : sel_bank;
        default:  ev_ref = 8'h00;
      endcase
    end
  end

  // Bank and row counters of the refresh scheme.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bank_cnt_r      <= 3'b000;
      row_cnt_r       <= 16'h0000;
      refresh_row_r   <= 16'h0000;
      refresh_pulse_r <= 1'b0;
    end else begin
      refresh_pulse_r <= 1'b0;
      if (second_edge && cmd_r == `CA_REF) begin
        refresh_row_r   <= row_cnt_r;
        refresh_pulse_r <= 1'b1;
        if (all_bank_r) begin
          // All banks at the current row, count zeroed, row moves on.
          bank_cnt_r <= 3'b000;
          row_cnt_r  <= row_cnt_r + 16'h0001;
        end else begin
          // Any bank order is taken; the eighth closes the set.
          // An exit in the same cycle zeroes the count before this refresh counts.
          bank_cnt_r <= (srx_r ? 3'b000 : bank_cnt_r) + 3'b001;
          if (bank_cnt_r == 3'b111 && !srx_r) begin
            row_cnt_r <= row_cnt_r + 16'h0001;
          end
        end
      end else if (srx_r) begin
        // Leaving self refresh resynchronises the count.
        bank_cnt_r <= 3'b000;
      end
    end
  end

  // Timing terms derived from the mode and control registers.
  always @* begin
    half_bl  = ctrl_r[`F_BL32] ? `HALF_BL32 : `HALF_BL16;
    rpst     = mode1_r[`F_RPST] ? `RPST_LONG : `RPST_SHORT;
    wpre     = mode1_r[`F_WPRE] ? `WPRE_LONG : `WPRE_SHORT;
    gap_base = {1'b0, mode2_r[`F_RL_LO +: 8]} + {1'b0, `SKEW_CYC} + {1'b0, half_bl}
               + {1'b0, rpst};
    if (ctrl_r[`F_ODT_EN]) begin
      // Terminated gap: RL+skew+BL/2+postamble-Termination_on_latency-ton+1.
      gap_base = gap_base + 9'h001;
      gap_sub  = {1'b0, ctrl_r[`F_TERMINATION_ON_LATENCY_LO +: 8]} + {1'b0, `TON_CYC};
    end else begin
      // Unterminated gap: RL+skew+BL/2+postamble-WL+preamble.
      gap_base = gap_base + {1'b0, wpre};
      gap_sub  = {1'b0, mode2_r[`F_WL_LO +: 8]};
    end
    gap_diff = gap_base - gap_sub;
    gap_nxt  = (gap_sub > gap_base) ? 8'h00 : gap_diff[7:0];
    // Read AP closes after read_to_precharge_cycles, plus eight for burst 32.
    rd_ap_dly = mode2_r[`F_READ_TO_PRECHARGE_CYCLES_LO +: 8] + (ctrl_r[`F_BL32] ? `BL32_EXTRA : 8'h00);
    // Write AP closes after WL+BL/2+write_recovery_cycles+1.
    wr_ap_dly = mode2_r[`F_WL_LO +: 8] + half_bl + mode1_r[`F_NWR_LO +: 8] + 8'h01;
  end

  // One tracker per bank; other banks keep working during a refresh.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_bank
      bank_state u_bank (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .tick         (second_edge),
        .act          (ev_act[gi]),
        .pre          (ev_pre[gi]),
        .rd_ap        (ev_rd[gi]),
        .wr_ap        (ev_wr[gi]),
        .ref_go       (ev_ref[gi]),
        .ras_cyc      (ctrl_r[`F_RAS_LO +: 8]),
        .rfc_cyc      (ctrl_r[`F_RFC_LO +: 8]),
        .rd_ap_dly    (rd_ap_dly),
        .wr_ap_dly    (wr_ap_dly),
        .active_r     (bank_active[gi]),
        .refreshing_r (bank_refreshing[gi])
      );
    end
  endgenerate

  // AHB-Lite address phase decode; only word transfers are expected.
  assign addr_ok   = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  // Read multiplexer; unmapped offsets read as zero.
  always @* begin
    case (haddr[7:0])
      `OFS_MODE1: rd_mux = mode1_r;
      `OFS_MODE2: rd_mux = mode2_r;
      `OFS_CTRL:  rd_mux = ctrl_r;
      `OFS_STAT:  rd_mux = {8'h00, bank_refreshing, bank_active, 5'h00, bank_cnt_r};
      `OFS_ROW:   rd_mux = {16'h0000, row_cnt_r};
      `OFS_GAP:   rd_mux = {24'h000000, gap_r};
      default:    rd_mux = 32'h00000000;
    endcase
  end

  // Bus slave: capture address phase, write in data phase, zero wait states.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_r      <= 1'b0;
      dph_wr_r   <= 1'b0;
      dph_addr_r <= 8'h00;
      hrdata_r   <= 32'h00000000;
      mode1_r    <= `RST_MODE1;
      mode2_r    <= `RST_MODE2;
      ctrl_r     <= `RST_CTRL;
      srx_r      <= 1'b0;
      gap_r      <= 8'h00;
    end else begin
      srx_r <= 1'b0;
      gap_r <= gap_nxt;
      dph_r <= addr_ok;
      if (addr_ok) begin
        dph_wr_r   <= hwrite;
        dph_addr_r <= haddr[7:0];
        if (!hwrite) begin
          hrdata_r <= rd_mux;
        end
      end
      if (dph_r && dph_wr_r) begin
        case (dph_addr_r)
          `OFS_MODE1: mode1_r <= hwdata;
          `OFS_MODE2: mode2_r <= hwdata;
          `OFS_CTRL: begin
            // The exit bit is a strobe and is never stored.
            ctrl_r <= hwdata & ~(32'h00000001 << `F_SRX);
            srx_r  <= hwdata[`F_SRX];
          end
          default: srx_r <= 1'b0;
        endcase
      end
    end
  end

endmodule // dram_refresh_ap_timing

// >>> dram_ref_consts.vh
`ifndef DRAM_REF_CONSTS_VH
`define DRAM_REF_CONSTS_VH

// Register byte offsets on the AHB-Lite slave.
`define OFS_MODE1     8'h00
`define OFS_MODE2     8'h04
`define OFS_CTRL      8'h08
`define OFS_STAT      8'h0C
`define OFS_ROW       8'h10
`define OFS_GAP       8'h14

// Reset values of the writable registers.
`define RST_MODE1     32'h00000A00
`define RST_MODE2     32'h00080E08
`define RST_CTRL      32'h10200600

// Mode register one: operand byte and write recovery cycles.
`define F_WPRE        2
`define F_RPST        7
`define F_NWR_LO      8
// Mode register two: read to precharge cycles, read and write latency.
`define F_READ_TO_PRECHARGE_CYCLES_LO     0
`define F_RL_LO       8
`define F_WL_LO       16
// Control register fields.
`define F_ODT_EN      0
`define F_BL32        1
`define F_SRX         2
`define F_TERMINATION_ON_LATENCY_LO   8
`define F_RFC_LO      16
`define F_RAS_LO      24

// First-edge command codes on command_address bits 4..0.
`define CA_REF        5'h08
`define CA_ACT        5'h01
`define CA_RDAP       5'h02
`define CA_WRAP       5'h04
`define CA_PRE        5'h10

// Timing counts in link clock cycles.
`define SKEW_CYC      8'h02
`define TON_CYC       8'h01
`define RPST_SHORT    8'h00
`define RPST_LONG     8'h01
`define WPRE_SHORT    8'h01
`define WPRE_LONG     8'h02
`define BL32_EXTRA    8'h08
`define HALF_BL16     8'h08
`define HALF_BL32     8'h10

`endif

// >>> bank_state.v
`timescale 1ns/100ps
// One bank: open row, RAS lockout of the internal precharge, refresh busy time.
module bank_state (
  input  wire       hclk,
  input  wire       hresetn,
  input  wire       tick,
  input  wire       act,
  input  wire       pre,
  input  wire       rd_ap,
  input  wire       wr_ap,
  input  wire       ref_go,
  input  wire [7:0] ras_cyc,
  input  wire [7:0] rfc_cyc,
  input  wire [7:0] rd_ap_dly,
  input  wire [7:0] wr_ap_dly,
  output reg        active_r,
  output reg        refreshing_r
);
  reg [7:0] ras_cnt_r;   // Second command edges left before an auto precharge may close the row.
  reg [7:0] ap_cnt_r;    // Second command edges left of the burst/recovery before auto precharge.
  reg [7:0] rfc_cnt_r;   // Second command edges left of the refresh cycle.
  reg       ap_pend_r;   // An auto precharge waits for its moment.

  // Counters run on second command edges; commands load them in the same tick.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_r     <= 1'b0;
      refreshing_r <= 1'b0;
      ras_cnt_r    <= 8'h00;
      ap_cnt_r     <= 8'h00;
      rfc_cnt_r    <= 8'h00;
      ap_pend_r    <= 1'b0;
    end else if (tick) begin
      if (ras_cnt_r != 8'h00) begin
        ras_cnt_r <= ras_cnt_r - 8'h01;
      end
      if (ap_cnt_r != 8'h00) begin
        ap_cnt_r <= ap_cnt_r - 8'h01;
      end
      // The row closes only when both the burst and the lockout are over.
      if (ap_pend_r && ras_cnt_r == 8'h00 && ap_cnt_r == 8'h00) begin
        active_r  <= 1'b0;
        ap_pend_r <= 1'b0;
      end
      // The refreshed bank goes back to idle when its cycle ends.
      if (rfc_cnt_r != 8'h00) begin
        rfc_cnt_r <= rfc_cnt_r - 8'h01;
        if (rfc_cnt_r == 8'h01) begin
          refreshing_r <= 1'b0;
        end
      end
      if (act) begin
        active_r  <= 1'b1;
        ras_cnt_r <= ras_cyc;
      end
      if (pre) begin
        active_r  <= 1'b0;
        ap_pend_r <= 1'b0;
      end
      // Auto precharge is accepted early and deferred internally.
      if (rd_ap) begin
        ap_pend_r <= 1'b1;
        ap_cnt_r  <= rd_ap_dly;
      end
      if (wr_ap) begin
        ap_pend_r <= 1'b1;
        ap_cnt_r  <= wr_ap_dly;
      end
      if (ref_go) begin
        refreshing_r <= 1'b1;
        rfc_cnt_r    <= rfc_cyc;
      end
    end
  end
endmodule // bank_state

// >>> dram_ref_checker_properties.sv
`timescale 1ns/100ps
// Watches the refresh decode and bank state outputs of the timing block.
module dram_ref_checker (
  input wire        hclk,
  input wire        hresetn,
  input wire        hreadyout,
  input wire        hresp,
  input wire        ck,
  input wire [7:0]  bank_active,
  input wire [7:0]  bank_refreshing,
  input wire [15:0] refresh_row_r,
  input wire        refresh_pulse_r
);
  reg       ck_seen_r;  // Link clock as sampled one hclk earlier.
  reg [3:0] since_r;    // Hclk cycles since the last link clock rise, saturating.

  // Counts hclk cycles from each sampled rise of the link clock.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ck_seen_r <= 1'b0;
      since_r   <= 4'hF;
    end else begin
      ck_seen_r <= ck;
      if (ck && !ck_seen_r) begin
        since_r <= 4'h0;
      end else if (since_r != 4'hF) begin
        since_r <= since_r + 4'h1;
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_pulse_once;
    refresh_pulse_r |=> !refresh_pulse_r;
  endproperty
  a_pulse_once: assert property (p_pulse_once) else $error("refresh pulse longer than one cycle");
  property p_pulse_after_ck;
    refresh_pulse_r |-> since_r <= 4'h8;
  endproperty
  a_pulse_after_ck: assert property (p_pulse_after_ck) else $error("refresh without link edge");
  property p_row_step;
    $changed(refresh_row_r) |-> refresh_row_r == $past(refresh_row_r) + 16'h0001;
  endproperty
  a_row_step: assert property (p_row_step) else $error("refresh row jumped");
  property p_row_with_pulse;
    $changed(refresh_row_r) |-> refresh_pulse_r;
  endproperty
  a_row_with_pulse: assert property (p_row_with_pulse) else $error("row moved without refresh");
  property p_new_ref_pulse;
    (|(bank_refreshing & ~$past(bank_refreshing))) |-> (refresh_pulse_r || $past(refresh_pulse_r));
  endproperty
  a_new_ref_pulse: assert property (p_new_ref_pulse) else $error("bank busy without refresh");
  property p_no_overlap;
    (bank_active & bank_refreshing) == 8'h00;
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("refreshing bank is open");
  property p_quiet;
    since_r == 4'hF |-> $stable(bank_active) && $stable(bank_refreshing) && !refresh_pulse_r;
  endproperty
  a_quiet: assert property (p_quiet) else $error("bank state moved with link idle");
  property p_bus_okay;
    hreadyout && !hresp;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or error reply");

  c_pulse: cover property (refresh_pulse_r);
  c_row: cover property ($changed(refresh_row_r));
  c_open: cover property ($rose(bank_active[2]));
endmodule // dram_ref_checker

bind dram_refresh_ap_timing dram_ref_checker chk (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .ck(ck), .bank_active(bank_active),
  .bank_refreshing(bank_refreshing), .refresh_row_r(refresh_row_r),
  .refresh_pulse_r(refresh_pulse_r));

// >>> lpddr_ctrl_model.sv
`timescale 1ns/100ps
// Controller side of the command bus: sends two-edge commands on a gated link clock.
module lpddr_ctrl_model (
  output reg       ck,
  output reg       cs,
  output reg [5:0] ca
);
  reg [7:0] done_r;  // Banks refreshed per bank since the last sync, all-bank refresh or completed set.
  integer   repeats; // Per-bank refreshes sent to a bank already done in this set.

  // The link clock stands low and the bus shows noise between frames.
  initial begin
    ck     = 1'b0;
    cs     = 1'b0;
    ca     = 6'h2A;
    done_r = 8'h00;
    repeats = 0;
  end

  // One frame: code on the first rise, bank on the second, then a quiet gap.
  task send(input c, input [5:0] a, input [5:0] b);
    begin
      if (c && a == 6'h08 && done_r[b[2:0]]) repeats = repeats + 1;
      #7;
      cs = c;
      ca = a;
      #160 ck = 1'b1;
      #160 ck = 1'b0;
      #80 cs = 1'b0;
      ca = b;
      #80 ck = 1'b1;
      #160 ck = 1'b0;
      #80 ca = ~b;
      // Quiet gap covers all spacing.
      #640;
      if (c && a == 6'h28) begin
        done_r = 8'h00;
      end
      if (c && a == 6'h08) begin
        done_r[b[2:0]] = 1'b1;
      end
      if (&done_r) begin
        done_r = 8'h00;
      end
    end
  endtask

  // A self refresh exit resynchronises the bank count.
  task sync;
    done_r = 8'h00;
  endtask
endmodule // lpddr_ctrl_model

// >>> dram_refresh_autoprecharge_timing_bench.sv
`timescale 1ns/100ps
`include "dram_ref_consts.vh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

module dram_refresh_autoprecharge_timing_bench;
  reg         hclk, hresetn, hsel, hwrite;  // Bus clock, reset and controls.
  reg  [31:0] haddr, hwdata, rd;            // Address, write data, last read.
  reg  [1:0]  htrans;                       // Transfer type.
  reg  [2:0]  hsize;                        // Always a word.
  wire [31:0] hrdata;                       // Read data.
  wire        hreadyout, hresp, ck, cs;     // Bus reply and link pins.
  wire [5:0]  ca;                           // Command bits.
  wire [7:0]  bank_active, bank_refreshing; // Bank state.
  wire [15:0] refresh_row_r;                // Row of the last refresh.
  wire        refresh_pulse_r;              // Refresh strobe.
  integer     errors, num_checks, i;        // Counters.
  reg  [2:0]  order [0:7];                  // Scattered refresh order.

  dram_refresh_ap_timing uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ck(ck), .cs(cs), .ca(ca),
    .bank_active(bank_active), .bank_refreshing(bank_refreshing),
    .refresh_row_r(refresh_row_r), .refresh_pulse_r(refresh_pulse_r));
  lpddr_ctrl_model ctl (.ck(ck), .cs(cs), .ca(ca));

  // Free-running bus clock.
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // Prints the counts and the verdict, then stops.
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask

  // Waits for the next edge with ready high, under a bound.
  task rdy;
    integer n;
    begin
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && n < 64) begin
        @(posedge hclk);
        n++;
      end
      if (n == 64) begin
        errors++;
        complete_run;
      end
    end
  endtask

  // One single word transfer: address phase, then data phase.
  task xfer(input w, input [7:0] a, input [31:0] d);
    begin
      haddr  <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      hsel   <= 1'b1;
      rdy;
      htrans <= 2'h0;
      hwdata <= d;
      rdy;
      rd = hrdata;
    end
  endtask

  // Reads one register and compares it.
  task chk_rd(input [7:0] a, input [31:0] e);
    begin
      @(posedge hclk);
      xfer(1'b0, a, 32'h00000000);
      `CHK(rd, e)
    end
  endtask

  // Sends one command and returns aligned to the bus clock.
  task cmd(input c, input [5:0] a, input [2:0] b);
    begin
      ctl.send(c, a, {3'h0, b});
      @(posedge hclk);
    end
  endtask

  // Times out a hung run.
  initial begin
    #3000000;
    errors++;
    complete_run;
  end

  // Main sequence.
  initial begin
    {hresetn, hsel, hwrite, haddr, hwdata, htrans} = 0;
    hsize = 3'h2;
    errors = 0;
    num_checks = 0;
    order = '{3'h1, 3'h3, 3'h0, 3'h2, 3'h4, 3'h7, 3'h5, 3'h6};
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    chk_rd(`OFS_MODE1, `RST_MODE1);
    chk_rd(`OFS_MODE2, `RST_MODE2);
    chk_rd(`OFS_CTRL, `RST_CTRL);
    xfer(1'b1, 8'h18, 32'hFFFFFFFF);
    chk_rd(8'h18, 32'h00000000);
    xfer(1'b1, `OFS_MODE1, 32'h00001284);
    chk_rd(`OFS_MODE1, 32'h00001284);
    chk_rd(`OFS_GAP, 32'h00000013);
    xfer(1'b1, `OFS_CTRL, 32'h10010600);
    $display("registers done");
    cmd(1'b1, 6'h28, 3'h0);
    `CHK(refresh_row_r, 16'h0000)
    chk_rd(`OFS_ROW, 32'h00000001);
    for (i = 0; i < 8; i++) begin
      cmd(1'b1, 6'h08, order[i]);
      `CHK(bank_refreshing[order[i]], 1'b1)
      `CHK(refresh_row_r, 16'h0001)
      chk_rd(`OFS_STAT, {8'h00, 8'h01 << order[i], 13'h0000, i[2:0] + 3'h1});
      `CHK(rd[2:0], i[2:0] + 3'h1)
    end
    chk_rd(`OFS_ROW, 32'h00000002);
    $display("per-bank set done");
    cmd(1'b1, 6'h08, 3'h0);
    cmd(1'b1, 6'h08, 3'h7);
    cmd(1'b1, 6'h28, 3'h0);
    `CHK(refresh_row_r, 16'h0002)
    chk_rd(`OFS_STAT, 32'h00FF0000);
    `CHK(rd[2:0], 3'h0)
    chk_rd(`OFS_ROW, 32'h00000003);
    $display("all-bank done");
    cmd(1'b1, 6'h08, 3'h3);
    cmd(1'b1, 6'h08, 3'h4);
    xfer(1'b1, `OFS_CTRL, 32'h10010604);
    ctl.sync;
    chk_rd(`OFS_STAT, 32'h00100000);
    `CHK(rd[2:0], 3'h0)
    chk_rd(`OFS_CTRL, 32'h10010600);
    $display("sync done");
    cmd(1'b1, 6'h08, 3'h5);
    cmd(1'b0, 6'h08, 3'h6);
    `CHK(bank_refreshing[6], 1'b0)
    chk_rd(`OFS_STAT, 32'h00200001);
    `CHK(rd[2:0], 3'h1)
    xfer(1'b1, `OFS_CTRL, 32'h02010600);
    xfer(1'b1, `OFS_MODE2, 32'h00080E01);
    cmd(1'b1, 6'h01, 3'h2);
    `CHK(bank_active[2], 1'b1)
    cmd(1'b1, 6'h02, 3'h2);
    `CHK(bank_active[2], 1'b1)
    cmd(1'b1, 6'h01, 3'h3);
    `CHK(bank_active[2], 1'b1)
    `CHK(bank_active[3], 1'b1)
    cmd(1'b1, 6'h10, 3'h3);
    `CHK(bank_active, 8'h00)
    `CHK(ctl.repeats, 0)
    $display("decode done");
    complete_run;
  end
endmodule // dram_refresh_autoprecharge_timing_bench
